// *** rtl/pmd_svc_pkg.sv ***
// Constants, register map and carrier types of the backplane PMD service block.
// Assumes a single 100 MHz clock standing in for the serial bit clock.
package pmd_svc_pkg;

	// Clock and energy detect timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int ENERGY_CHANGE_MAX_NS = 750;
	// Two cycles of input and output registering are taken off the limit
	localparam int ENERGY_PIPE_CYC = 2;
	localparam int ENERGY_QUIET_CYC = ENERGY_CHANGE_MAX_NS / CLK_PERIOD_NS - ENERGY_PIPE_CYC;
	// Delay budget through the block and medium, in bit times
	localparam int PATH_DELAY_MAX_BITS = 256;
	localparam int MEDIUM_RTT_MAX_BITS = 40;
	localparam int BLOCK_DELAY_BITS = 2;

	// Register offsets (byte addresses)
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STAT_OFS = 8'h04;
	localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
	localparam logic [7:0] IRQ_MASK_OFS = 8'h0C;

	// Control fields
	localparam int CTRL_TX_OFF_BIT = 0;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;

	// Status fields
	localparam int STAT_ENERGY_BIT = 0;
	localparam int STAT_TX_OFF_BIT = 1;
	localparam int STAT_RX_QUIET_BIT = 2;
	localparam int STAT_TX_QUIET_BIT = 3;

	// Interrupt event fields
	localparam int IRQ_W = 3;
	localparam int IRQ_ENERGY_UP_BIT = 0;
	localparam int IRQ_ENERGY_DOWN_BIT = 1;
	localparam int IRQ_TX_OFF_BIT = 2;
	localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

	// Energy detect states, one-hot
	typedef enum logic [1:0] {
		ENERGY_FAIL = 2'h1,
		ENERGY_OK = 2'h2
	} energy_state_t;

	// Requests arriving from the attachment sublayer
	typedef struct packed {
		logic tx_bit;
		logic receive_idle_request;
		logic transmit_idle_request;
	} pcs_req_t;

	// Indications returned to the attachment sublayer
	typedef struct packed {
		logic rx_bit;
		logic line_energy_present;
	} pcs_ind_t;

	// Power and line controls toward the analog front end
	typedef struct packed {
		logic tx_line;
		logic transmitter_off_control;
		logic rx_low_power;
		logic tx_low_power;
	} afe_ctl_t;

endpackage : pmd_svc_pkg

// *** rtl/pmd_service.sv ***
// Service-interface logic of a backplane PMD: bit streams, energy detect,
// quiet requests, transmitter disable, and a small register file.
// Assumes the attachment sublayer and the line front end share clk.
// Design notes
// Clocking
// - One clock; each edge stands for one serial bit time.
// - Every input is taken as already synchronous to clk.
// - No clock enable; all flops load on every edge.
//
// Transmit side
// - tx_bit registered once, then driven onto tx_line.
// - One cycle from request to line, far inside the budget.
// - While off, tx_line sits at 0 with no transitions.
// - Off means transmit quiet or the software off bit.
// - Off output and line level come from the same edge,
//   so no stray bit escapes when the transmitter turns off.
// - Leaving off: the next bit of the stream goes out
//   one cycle after the request falls.
//
// Receive side
// - line_rx captured into rx_s, then copied into rx_prev.
// - A difference between the two is a line transition.
// - rx_bit is rx_s one edge later: two cycles from the pin.
// - rx_bit is held 0 whenever the energy state is FAIL,
//   so downstream logic never sees stale received data.
//
// Energy detect
// - FAIL to OK on the first transition seen.
// - OK to FAIL after QUIET_CYC cycles with no transition.
// - QUIET_CYC default leaves room for the capture and
//   output flops inside the 750 ns limit.
// - Rising OK needs only one edge; a noisy idle line can
//   therefore raise OK briefly. Trade: fastest wake-up.
// - Status bit and service indication share one flop,
//   so the management copy can never lag or lead.
//
// Quiet requests
// - Both requests are registered levels, one cycle late.
// - With ENERGY_SAVING cleared both are forced FALSE and
//   the low-power outputs stay 0 and off follows only software.
// - Receive quiet only lowers receiver power; the energy
//   detector keeps running so a wake-up is not missed.
//
// Register file
// - CTRL: bit 0 switches the transmitter off by software.
// - STATUS: read only; energy, off, rx quiet, tx quiet.
// - IRQ_STAT: sticky events, write one to clear.
// - IRQ_MASK: same layout, one enables the interrupt.
// - Events: energy rises, energy falls, transmitter off.
// - An event in the cycle of its clear wins; nothing lost.
// - Read data stands only in the cycle after the strobe,
//   zero otherwise, so a bus mux can simply OR it in.
// - Unmapped reads return zero; unmapped writes vanish.
// - No wait states; back-to-back strobes are served.
//
// Interrupt
// - irq is a level, high while any unmasked bit is set.
// - It is combinational from flops; no glitch from inputs.
//
// Reset
// - Asynchronous, active high; all state to constants.
// - After release energy is FAIL and the line idles at 0.
// - The first access may come at the first edge after.
//
// Hazards and limits
// - A mid-run reset drops sticky events without a report.
// - The software off bit also raises the off event.
// - Loopback, fault reporting and the analog front end
//   are outside this block.
// - A line that toggles slower than QUIET_CYC cycles is
//   reported as quiet; this is the intended behaviour.
//
// Parameters
// - ENERGY_SAVING: one enables the quiet requests.
// - QUIET_CYC: quiet cycles before FAIL, checked below.
//
// Design decisions made here: the strobed register port and the register offsets.
`timescale 1ns/1ps

module pmd_service #(
	parameter bit ENERGY_SAVING = 1'b1,
	parameter int QUIET_CYC = pmd_svc_pkg::ENERGY_QUIET_CYC
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire pmd_svc_pkg::pcs_req_t pcs_req,
	output pmd_svc_pkg::pcs_ind_t pcs_ind,
	input wire logic line_rx,
	output pmd_svc_pkg::afe_ctl_t afe_ctl,
	output logic mgmt_energy_present_status,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic irq
);

	localparam int CNT_W = $clog2(QUIET_CYC + 1);

	// Refuse settings the quiet detector or delay budget cannot serve
	// Quiet count range and delay budget checks
	if (QUIET_CYC < 1 || QUIET_CYC > pmd_svc_pkg::ENERGY_QUIET_CYC) begin : g_bad_quiet
		$error("QUIET_CYC out of range");
	end
	if (pmd_svc_pkg::BLOCK_DELAY_BITS + pmd_svc_pkg::MEDIUM_RTT_MAX_BITS
		> pmd_svc_pkg::PATH_DELAY_MAX_BITS) begin : g_bad_delay
		$error("Path delay budget exceeded");
	end

	// Complete state of the block
	typedef struct packed {
		logic tx_line;
		logic rx_s;
		logic rx_prev;
		logic rx_bit;
		logic rx_quiet;
		logic tx_quiet;
		logic tx_off;
		pmd_svc_pkg::energy_state_t energy;
		logic [CNT_W-1:0] quiet_cnt;
		logic sw_tx_off;
		logic [pmd_svc_pkg::IRQ_W-1:0] irq_stat;
		logic [pmd_svc_pkg::IRQ_W-1:0] irq_mask;
		logic [31:0] rdata;
	} state_t;

	state_t st_ff;
	state_t nxt_st;

	// Compare a register address against an offset
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
		return addr == ofs;
	endfunction : hit

	// Build the read-only status word from the current state
	function automatic logic [31:0] status_word(input state_t s);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[pmd_svc_pkg::STAT_ENERGY_BIT] = (s.energy == pmd_svc_pkg::ENERGY_OK);
		w[pmd_svc_pkg::STAT_TX_OFF_BIT] = s.tx_off;
		w[pmd_svc_pkg::STAT_RX_QUIET_BIT] = s.rx_quiet;
		w[pmd_svc_pkg::STAT_TX_QUIET_BIT] = s.tx_quiet;
		return w;
	endfunction : status_word

	// Next-state logic
	always_comb begin
		logic energy_ok;
		logic rx_edge;
		logic [pmd_svc_pkg::IRQ_W-1:0] ev;
		logic [pmd_svc_pkg::IRQ_W-1:0] clr;
		energy_ok = 1'b0;
		rx_edge = 1'b0;
		ev = pmd_svc_pkg::IRQ_RST;
		clr = pmd_svc_pkg::IRQ_RST;
		nxt_st = st_ff;

		nxt_st.rx_quiet = ENERGY_SAVING & pcs_req.receive_idle_request;
		nxt_st.tx_quiet = ENERGY_SAVING & pcs_req.transmit_idle_request;

		nxt_st.tx_off = nxt_st.tx_quiet | st_ff.sw_tx_off;

		nxt_st.tx_line = nxt_st.tx_off ? 1'b0 : pcs_req.tx_bit;

		// Line receive capture and transition detect
		nxt_st.rx_s = line_rx;
		nxt_st.rx_prev = st_ff.rx_s;
		rx_edge = st_ff.rx_s ^ st_ff.rx_prev;

		case (st_ff.energy)
			pmd_svc_pkg::ENERGY_FAIL: begin
				nxt_st.quiet_cnt = '0;
				if (rx_edge) begin
					nxt_st.energy = pmd_svc_pkg::ENERGY_OK;
				end
			end
			pmd_svc_pkg::ENERGY_OK: begin
				if (rx_edge) begin
					nxt_st.quiet_cnt = '0;
				end else if (st_ff.quiet_cnt == CNT_W'(QUIET_CYC - 1)) begin
					nxt_st.quiet_cnt = '0;
					nxt_st.energy = pmd_svc_pkg::ENERGY_FAIL;
				end else begin
					nxt_st.quiet_cnt = st_ff.quiet_cnt + CNT_W'(1);
				end
			end
			default: begin
				nxt_st.quiet_cnt = '0;
				nxt_st.energy = pmd_svc_pkg::ENERGY_FAIL;
			end
		endcase
		energy_ok = (nxt_st.energy == pmd_svc_pkg::ENERGY_OK);

		nxt_st.rx_bit = energy_ok ? st_ff.rx_s : 1'b0;

		ev[pmd_svc_pkg::IRQ_ENERGY_UP_BIT] = energy_ok
			& (st_ff.energy != pmd_svc_pkg::ENERGY_OK);
		ev[pmd_svc_pkg::IRQ_ENERGY_DOWN_BIT] = !energy_ok
			& (st_ff.energy == pmd_svc_pkg::ENERGY_OK);
		ev[pmd_svc_pkg::IRQ_TX_OFF_BIT] = nxt_st.tx_off & !st_ff.tx_off;

		// Register writes
		if (reg_wr && hit(reg_addr, pmd_svc_pkg::CTRL_OFS)) begin
			nxt_st.sw_tx_off = reg_wdata[pmd_svc_pkg::CTRL_TX_OFF_BIT];
		end
		if (reg_wr && hit(reg_addr, pmd_svc_pkg::IRQ_STAT_OFS)) begin
			clr = reg_wdata[pmd_svc_pkg::IRQ_W-1:0];
		end
		if (reg_wr && hit(reg_addr, pmd_svc_pkg::IRQ_MASK_OFS)) begin
			nxt_st.irq_mask = reg_wdata[pmd_svc_pkg::IRQ_W-1:0];
		end

		// Sticky events, a new event beats a clear
		nxt_st.irq_stat = (st_ff.irq_stat & ~clr) | ev;

		// Register reads, data stands one cycle after the strobe
		nxt_st.rdata = 32'h0000_0000;
		if (reg_rd) begin
			case (1'b1)
				hit(reg_addr, pmd_svc_pkg::CTRL_OFS): begin
					nxt_st.rdata[pmd_svc_pkg::CTRL_TX_OFF_BIT] = st_ff.sw_tx_off;
				end
				hit(reg_addr, pmd_svc_pkg::STAT_OFS): begin
					nxt_st.rdata = status_word(st_ff);
				end
				hit(reg_addr, pmd_svc_pkg::IRQ_STAT_OFS): begin
					nxt_st.rdata[pmd_svc_pkg::IRQ_W-1:0] = st_ff.irq_stat;
				end
				hit(reg_addr, pmd_svc_pkg::IRQ_MASK_OFS): begin
					nxt_st.rdata[pmd_svc_pkg::IRQ_W-1:0] = st_ff.irq_mask;
				end
				default: begin
					nxt_st.rdata = 32'h0000_0000;
				end
			endcase
		end
	end

	// State register
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_ff.tx_line <= 1'b0;
			st_ff.rx_s <= 1'b0;
			st_ff.rx_prev <= 1'b0;
			st_ff.rx_bit <= 1'b0;
			st_ff.rx_quiet <= 1'b0;
			st_ff.tx_quiet <= 1'b0;
			st_ff.tx_off <= 1'b0;
			st_ff.energy <= pmd_svc_pkg::ENERGY_FAIL;
			st_ff.quiet_cnt <= '0;
			st_ff.sw_tx_off <= pmd_svc_pkg::CTRL_RST[pmd_svc_pkg::CTRL_TX_OFF_BIT];
			st_ff.irq_stat <= pmd_svc_pkg::IRQ_RST;
			st_ff.irq_mask <= pmd_svc_pkg::IRQ_RST;
			st_ff.rdata <= 32'h0000_0000;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Outputs, all from flip-flops except the interrupt level and the two energy-present decodes of the energy state
	assign pcs_ind.rx_bit = st_ff.rx_bit;
	assign pcs_ind.line_energy_present = (st_ff.energy == pmd_svc_pkg::ENERGY_OK);
	assign mgmt_energy_present_status = (st_ff.energy == pmd_svc_pkg::ENERGY_OK);
	assign afe_ctl.tx_line = st_ff.tx_line;
	assign afe_ctl.transmitter_off_control = st_ff.tx_off;
	assign afe_ctl.rx_low_power = st_ff.rx_quiet;
	assign afe_ctl.tx_low_power = st_ff.tx_quiet;
	assign reg_rdata = st_ff.rdata;
	assign irq = |(st_ff.irq_stat & st_ff.irq_mask);

endmodule : pmd_service

// *** test/pmd_service_chk.sv ***
// Port checker for the PMD service block.
// Assumes one clock, bound to every pmd_service instance.
`timescale 1ns/1ps

module pmd_service_chk #(
	parameter int QUIET_CYC = 73
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire pmd_svc_pkg::pcs_req_t pcs_req,
	input wire pmd_svc_pkg::pcs_ind_t pcs_ind,
	input wire logic line_rx,
	input wire pmd_svc_pkg::afe_ctl_t afe_ctl,
	input wire logic mgmt_energy_present_status,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	logic [7:0] still_ff;
	// Cycles since the last line edge
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			still_ff <= 8'h0;
		end else begin
			still_ff <= $changed(line_rx) ? 8'h0 : still_ff + 8'(still_ff != 8'hFF);
		end
	end
	sequence s_edge;
		$changed(line_rx);
	endsequence
	a_tx_follows: assert property (!afe_ctl.transmitter_off_control |-> afe_ctl.tx_line == $past(pcs_req.tx_bit)) else $error("tx line lost bit");
	a_off_const: assert property (afe_ctl.transmitter_off_control |-> !afe_ctl.tx_line) else $error("tx line moves while off");
	a_txq_off: assert property (pcs_req.transmit_idle_request |=> afe_ctl.transmitter_off_control && afe_ctl.tx_low_power) else $error("tx quiet ignored");
	a_rxq_power: assert property (afe_ctl.rx_low_power == $past(pcs_req.receive_idle_request)) else $error("rx power wrong");
	a_mgmt_mirror: assert property (mgmt_energy_present_status == pcs_ind.line_energy_present) else $error("status mirror");
	a_rx_path: assert property (pcs_ind.line_energy_present |-> pcs_ind.rx_bit == $past(line_rx, 2)) else $error("rx bit wrong");
	a_rx_fail_zero: assert property (!pcs_ind.line_energy_present |-> !pcs_ind.rx_bit) else $error("rx bit in fail");
	a_energy_up: assert property (s_edge |-> ##[1:3] pcs_ind.line_energy_present) else $error("energy late up");
	a_energy_down: assert property (still_ff > QUIET_CYC + 3 |-> !pcs_ind.line_energy_present) else $error("energy late down");
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0) else $error("stray read data");
endmodule : pmd_service_chk

bind pmd_service pmd_service_chk #(.QUIET_CYC(QUIET_CYC)) chk_inst (.clk(clk), .sys_rst(sys_rst),
	.pcs_req(pcs_req), .pcs_ind(pcs_ind), .line_rx(line_rx), .afe_ctl(afe_ctl),
	.mgmt_energy_present_status(mgmt_energy_present_status), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata));

// *** test/pcs_partner.sv ***
// Behavioural attachment sublayer facing the PMD service block.
// Assumes the shared clock and reset of the block.
`timescale 1ns/1ps

module pcs_partner (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic tx_quiet_cmd,
	input wire pmd_svc_pkg::pcs_ind_t pcs_ind,
	output pmd_svc_pkg::pcs_req_t pcs_req,
	output logic rx_data
);
	logic [2:0] cnt_ff;
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_ff <= 3'h0;
			pcs_req <= '0;
		end else begin
			cnt_ff <= cnt_ff + 3'h1;
			pcs_req.tx_bit <= cnt_ff[0] ^ cnt_ff[2];
			pcs_req.receive_idle_request <= !pcs_ind.line_energy_present;
			pcs_req.transmit_idle_request <= tx_quiet_cmd;
		end
	end
	assign rx_data = pcs_ind.line_energy_present & pcs_ind.rx_bit;
endmodule : pcs_partner

// *** test/tb_pmd_service.sv ***
// Register-level testbench for the PMD service block.
// Assumes the partner model and the bound checker.
`timescale 1ns/1ps

module tb_pmd_service;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic line_rx = 1'b0;
	logic line_on = 1'b0;
	logic tx_quiet_cmd = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic irq;
	int n_fail = 0;
	int checks_done = 0;
	pmd_svc_pkg::pcs_req_t pcs_req;
	pmd_svc_pkg::pcs_ind_t pcs_ind;
	// Clock and toggling line source
	always #5 clk = ~clk;
	always @(posedge clk) if (line_on) line_rx <= ~line_rx;
	pmd_service pmd_service_inst (.clk(clk), .sys_rst(sys_rst), .pcs_req(pcs_req),
		.pcs_ind(pcs_ind), .line_rx(line_rx), .afe_ctl(), .mgmt_energy_present_status(),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .irq(irq));
	pcs_partner pcs_partner_inst (.clk(clk), .sys_rst(sys_rst), .tx_quiet_cmd(tx_quiet_cmd),
		.pcs_ind(pcs_ind), .pcs_req(pcs_req), .rx_data());
	task automatic end_of_test;
		$display("checks %0d, mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : end_of_test
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value %s: expected %h, seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk("reg", e, reg_rdata);
		@(posedge clk);
	endtask : rd
	task automatic wait_energy(input logic v);
		for (int i = 0; i < 90 && pcs_ind.line_energy_present !== v; i++) @(posedge clk);
		if (pcs_ind.line_energy_present !== v) begin
			chk("energy", 32'(v), 32'(pcs_ind.line_energy_present));
			end_of_test();
		end
		// Let the partner's receive quiet answer reach the status flops
		repeat (2) @(posedge clk);
	endtask : wait_energy
	// Main sequence
	initial begin
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		wr(8'h10, 32'hFFFF_FFFF);
		for (int i = 0; i < 5; i++) rd(8'(4 * i), (i == 1) ? 32'h4 : 32'h0);
		line_on <= 1'b1;
		wait_energy(1'b1);
		rd(8'h04, 32'h1);
		rd(8'h08, 32'h1);
		chk("irq", 32'h0, 32'(irq));
		wr(8'h0C, 32'h7);
		chk("irq", 32'h1, 32'(irq));
		wr(8'h08, 32'h1);
		chk("irq", 32'h0, 32'(irq));
		line_on <= 1'b0;
		wait_energy(1'b0);
		rd(8'h04, 32'h4);
		rd(8'h08, 32'h2);
		wr(8'h08, 32'h2);
		tx_quiet_cmd <= 1'b1;
		repeat (3) @(posedge clk);
		rd(8'h04, 32'hE);
		rd(8'h08, 32'h4);
		tx_quiet_cmd <= 1'b0;
		wr(8'h08, 32'h4);
		wr(8'h00, 32'h1);
		rd(8'h04, 32'h6);
		rd(8'h00, 32'h1);
		sys_rst <= 1'b1;
		@(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		rd(8'h00, 32'h0);
		rd(8'h0C, 32'h0);
		end_of_test();
	end
endmodule : tb_pmd_service
